//--- pcfg_params.svh
// Register offsets, reset values and page codes of the port configuration block
`ifndef PCFG_PARAMS_SVH
`define PCFG_PARAMS_SVH
`define PCFG_ADDR_P2_LATCH    8'ha0
`define PCFG_ADDR_P2_OUTTYPE  8'ha6
`define PCFG_ADDR_P3_LATCH    8'hb0
`define PCFG_ADDR_P2_BYPASS   8'hd6
`define PCFG_ADDR_P2_ANALOG   8'hf3
`define PCFG_ADDR_P2_DRIVE    8'hfb
`define PCFG_RST_P2_LATCH     8'hff
`define PCFG_RST_P2_OUTTYPE   8'h00
`define PCFG_RST_P3_LATCH     8'hff
`define PCFG_RST_P2_BYPASS    8'h00
`define PCFG_RST_P2_ANALOG    8'hff
`define PCFG_RST_P2_DRIVE     8'h00
`define PCFG_PAGE_CONFIG      8'h0f
`define PCFG_BYTE_BITS        8
`endif

//--- pcfg_pkg.sv
// Types shared by the port configuration block
package pcfg_pkg;
	`include "pcfg_params.svh"
	typedef logic [`PCFG_BYTE_BITS-1:0] pcfg_byte_t;
	typedef logic [2:0]                 pcfg_bit_t;
endpackage : pcfg_pkg

//--- pcfg_pin_cell.sv
// Per-pin output control for one port pin
`timescale 1ns/1ps
module pcfg_pin_cell
	import pcfg_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic latch_bit,
	input  wire logic digital_bit,
	input  wire logic push_pull_bit,
	input  wire logic drive_bit,
	input  wire logic pin_in,
	output logic      pin_out,
	output logic      pin_oe,
	output logic      pullup_en,
	output logic      rx_en,
	output logic      strong_drive,
	output logic      pin_level
);
	logic out_d, oe_d, pu_d, rx_d, drv_d, lvl_d;
	logic out_q, oe_q, pu_q, rx_q, drv_q, lvl_q;

	// Driver style; analog mode forces every output but pin_out off
	always_comb begin
		out_d = latch_bit;
		oe_d  = digital_bit & (push_pull_bit | ~latch_bit);
		pu_d  = digital_bit & ~push_pull_bit & latch_bit;
		rx_d  = digital_bit;
		drv_d = digital_bit & drive_bit;
		lvl_d = digital_bit & pin_in;
	end

	// Outputs come from flops; pin level reads one cycle late
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_q <= 1'b1;
			oe_q  <= 1'b0;
			pu_q  <= 1'b0;
			rx_q  <= 1'b0;
			drv_q <= 1'b0;
			lvl_q <= 1'b0;
		end else begin
			out_q <= out_d;
			oe_q  <= oe_d;
			pu_q  <= pu_d;
			rx_q  <= rx_d;
			drv_q <= drv_d;
			lvl_q <= lvl_d;
		end
	end

	assign pin_out      = out_q;
	assign pin_oe       = oe_q;
	assign pullup_en    = pu_q;
	assign rx_en        = rx_q;
	assign strong_drive = drv_q;
	assign pin_level    = lvl_q;
endmodule : pcfg_pin_cell

//--- pcfg_port.sv
// Port 2 configuration registers and port 3 data latch
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Writing a port data register loads each bit into that pin's latch.
// - Reading a port data register returns pin levels, not latch contents.
// - Port data registers work on every page and allow single-bit writes.
// - Port 2 configuration registers respond only when page F is selected.
// - Analog pins lose weak pullup, digital driver and digital receiver.
// - Analog select bit 0 makes the pin analog; 1 keeps it digital.
// - Output-type bit is ignored while the pin is analog.
// - Output-type bit 0 gives open-drain, 1 gives push-pull.
// - Bypass bit 1 makes the crossbar skip that pin; 0 leaves it free.
// - Drive-level bit 0 selects low strength, 1 selects high strength.
module pcfg_port
	import pcfg_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire pcfg_byte_t sfr_addr,
	input  wire pcfg_byte_t sfr_page,
	input  wire logic       sfr_wr,
	input  wire pcfg_byte_t sfr_wdata,
	input  wire logic       sfr_bit_wr,
	input  wire pcfg_bit_t  sfr_bit_sel,
	input  wire logic       sfr_bit_val,
	input  wire logic       sfr_rd,
	output pcfg_byte_t      sfr_rdata,
	output logic            sfr_rvalid,
	input  wire pcfg_byte_t p2_pin_in,
	output pcfg_byte_t      p2_pin_out,
	output pcfg_byte_t      p2_pin_oe,
	output pcfg_byte_t      p2_pullup_en,
	output pcfg_byte_t      p2_rx_en,
	output pcfg_byte_t      p2_strong_drive,
	output pcfg_byte_t      p2_xbar_skip,
	input  wire pcfg_byte_t p3_pin_in,
	output pcfg_byte_t      p3_pin_out
);
	////////////////////////////////////////////////////////////////////////////
	// Reset release; assertion is immediate, release waits two edges so that
	// no flop leaves reset on an edge that the raw release could straddle
	logic rst_meta_d, rst_meta_q, rst_n_d, rst_n;
	always_comb begin
		rst_meta_d = 1'b1;
		rst_n_d    = rst_meta_q; // Only the second stage reads the first
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= rst_meta_d;
			rst_n      <= rst_n_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address decode
	// Data latches answer on every page; configuration registers only on the
	// configuration page, so a stray page value cannot reconfigure a pin
	logic cfg_page, hit_p2, hit_p3, hit_out, hit_byp, hit_ana, hit_drv;
	always_comb begin
		cfg_page = (sfr_page == `PCFG_PAGE_CONFIG);
		hit_p2   = (sfr_addr == `PCFG_ADDR_P2_LATCH);
		hit_p3   = (sfr_addr == `PCFG_ADDR_P3_LATCH);
		hit_out  = cfg_page && (sfr_addr == `PCFG_ADDR_P2_OUTTYPE);
		hit_byp  = cfg_page && (sfr_addr == `PCFG_ADDR_P2_BYPASS);
		hit_ana  = cfg_page && (sfr_addr == `PCFG_ADDR_P2_ANALOG);
		hit_drv  = cfg_page && (sfr_addr == `PCFG_ADDR_P2_DRIVE);
	end

	////////////////////////////////////////////////////////////////////////////
	// Write strobes; a byte write wins over a bit write in the same cycle,
	// so a bit change is never half applied on top of a byte store
	logic wr_p2, wr_p3, wr_out, wr_byp, wr_ana, wr_drv, bit_p2, bit_p3;
	always_comb begin
		wr_p2  = sfr_wr && hit_p2;
		wr_p3  = sfr_wr && hit_p3;
		wr_out = sfr_wr && hit_out;
		wr_byp = sfr_wr && hit_byp;
		wr_ana = sfr_wr && hit_ana;
		wr_drv = sfr_wr && hit_drv;
		bit_p2 = !sfr_wr && sfr_bit_wr && hit_p2;
		bit_p3 = !sfr_wr && sfr_bit_wr && hit_p3;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	pcfg_byte_t p2_latch_q, p3_latch_q, out_type_q, bypass_q, analog_q, drive_q;
	pcfg_byte_t p2_latch_d, p3_latch_d, out_type_d, bypass_d, analog_d, drive_d;
	pcfg_byte_t bit_mask;

	// Byte writes replace a register; bit writes touch only the data latches
	always_comb begin
		bit_mask   = pcfg_byte_t'(8'h01 << sfr_bit_sel);
		p2_latch_d = p2_latch_q;
		p3_latch_d = p3_latch_q;
		out_type_d = out_type_q;
		bypass_d   = bypass_q;
		analog_d   = analog_q;
		drive_d    = drive_q;
		if (wr_p2)  p2_latch_d = sfr_wdata;
		if (wr_p3)  p3_latch_d = sfr_wdata;
		if (wr_out) out_type_d = sfr_wdata;
		if (wr_byp) bypass_d   = sfr_wdata;
		if (wr_ana) analog_d   = sfr_wdata;
		if (wr_drv) drive_d    = sfr_wdata;
		// Read-modify-write on the latch, never on the pin level, so a pin
		// held low from outside cannot clear its neighbours' latch bits
		if (bit_p2)
			p2_latch_d = sfr_bit_val ? (p2_latch_q | bit_mask)
			                         : (p2_latch_q & ~bit_mask);
		if (bit_p3)
			p3_latch_d = sfr_bit_val ? (p3_latch_q | bit_mask)
			                         : (p3_latch_q & ~bit_mask);
	end

	// Port 2 pins come up digital, open-drain and high, so each one idles on its
	// weak pullup until software configures it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			p2_latch_q <= `PCFG_RST_P2_LATCH;
			p3_latch_q <= `PCFG_RST_P3_LATCH;
			out_type_q <= `PCFG_RST_P2_OUTTYPE;
			bypass_q   <= `PCFG_RST_P2_BYPASS;
			analog_q   <= `PCFG_RST_P2_ANALOG;
			drive_q    <= `PCFG_RST_P2_DRIVE;
		end else begin
			p2_latch_q <= p2_latch_d;
			p3_latch_q <= p3_latch_d;
			out_type_q <= out_type_d;
			bypass_q   <= bypass_d;
			analog_q   <= analog_d;
			drive_q    <= drive_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Port 2 pin cells, one per pin
	// Each cell keeps its own flops, so pad controls never glitch while the
	// address decode settles; the cost is one cycle from write to pin
	pcfg_byte_t p2_level;
	genvar gi;
	generate
		for (gi = 0; gi < `PCFG_BYTE_BITS; gi++) begin : g_pin
			pcfg_pin_cell u_cell (
				.sys_clk      (sys_clk),
				.rst_n        (rst_n),
				.latch_bit    (p2_latch_q[gi]),
				.digital_bit  (analog_q[gi]),
				.push_pull_bit(out_type_q[gi]),
				.drive_bit    (drive_q[gi]),
				.pin_in       (p2_pin_in[gi]),
				.pin_out      (p2_pin_out[gi]),
				.pin_oe       (p2_pin_oe[gi]),
				.pullup_en    (p2_pullup_en[gi]),
				.rx_en        (p2_rx_en[gi]),
				.strong_drive (p2_strong_drive[gi]),
				.pin_level    (p2_level[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Crossbar skip and port 3 drive
	// One more flop stage so that every output leaves a flop; the price is
	// one cycle of latency, matching the two-edge delay of the port 2 pins
	pcfg_byte_t skip_d, skip_q, p3_out_d, p3_out_q;
	always_comb begin
		skip_d   = bypass_q;
		p3_out_d = p3_latch_q;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			skip_q   <= `PCFG_RST_P2_BYPASS;
			p3_out_q <= `PCFG_RST_P3_LATCH;
		end else begin
			skip_q   <= skip_d;
			p3_out_q <= p3_out_d;
		end
	end
	assign p2_xbar_skip = skip_q;
	assign p3_pin_out   = p3_out_q;

	////////////////////////////////////////////////////////////////////////////
	// Read path; data registers return pin levels
	pcfg_byte_t rdata_d, rdata_q;
	logic       rvalid_d, rvalid_q;
	// Read data hold until the next read, so a slow reader may take them late;
	// every read, mapped or not, gets a one-cycle valid
	always_comb begin
		rdata_d  = rdata_q;
		rvalid_d = sfr_rd;
		if (sfr_rd) begin
			rdata_d = 8'h00; // Unmapped and off-page reads return zero
			// Port 3 has no analog select here, so its pins read back raw
			if (hit_p2)       rdata_d = p2_level;
			else if (hit_p3)  rdata_d = p3_pin_in;
			else if (hit_out) rdata_d = out_type_q;
			else if (hit_byp) rdata_d = bypass_q;
			else if (hit_ana) rdata_d = analog_q;
			else if (hit_drv) rdata_d = drive_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end
	assign sfr_rdata  = rdata_q;
	assign sfr_rvalid = rvalid_q;
endmodule : pcfg_port

//--- pcfg_pads.sv
// Pad model standing for the port 2 pins and an outside driver
`timescale 1ns/1ps
module pcfg_pads
	import pcfg_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire pcfg_byte_t p2_pin_out,
	input  wire pcfg_byte_t p2_pin_oe,
	input  wire pcfg_byte_t p2_pullup_en,
	input  wire pcfg_byte_t ext_en,
	input  wire pcfg_byte_t ext_val,
	output pcfg_byte_t      p2_pin_in
);
	logic wander = 1'b0;
	// A pin nobody drives or pulls flips each cycle, never a clean level
	always @(posedge sys_clk) wander <= ~wander;
	// Own driver beats the outside one; the weak pullup loses to both
	assign p2_pin_in = (p2_pin_oe & p2_pin_out) | (~p2_pin_oe & ext_en & ext_val)
		| (~p2_pin_oe & ~ext_en & (p2_pullup_en | {8{wander}}));
endmodule : pcfg_pads

//--- pcfg_port_sva.sv
// Assertion checker bound to the port configuration block
`timescale 1ns/1ps
module pcfg_port_sva
	import pcfg_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire pcfg_byte_t sfr_addr,
	input wire pcfg_byte_t sfr_page,
	input wire logic       sfr_wr,
	input wire pcfg_byte_t sfr_wdata,
	input wire logic       sfr_rd,
	input wire pcfg_byte_t sfr_rdata,
	input wire logic       sfr_rvalid,
	input wire pcfg_byte_t p2_pin_out,
	input wire pcfg_byte_t p2_pin_oe,
	input wire pcfg_byte_t p2_pullup_en,
	input wire pcfg_byte_t p2_rx_en,
	input wire pcfg_byte_t p2_xbar_skip
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	wire cfg_page = sfr_page == 8'h0f;
	rd_answer_a: assert property (sfr_rd |=> sfr_rvalid)
		else $error("read not answered");
	rd_pulse_a: assert property (!sfr_rd |=> !sfr_rvalid)
		else $error("stray read valid");
	p2_write_a: assert property (sfr_wr && sfr_addr == 8'ha0 |->
		##2 p2_pin_out == $past(sfr_wdata, 2)) else $error("latch not loaded");
	skip_write_a: assert property (sfr_wr && sfr_addr == 8'hd6 && cfg_page |->
		##2 p2_xbar_skip == $past(sfr_wdata, 2)) else $error("bypass not loaded");
	skip_refused_a: assert property (sfr_wr && sfr_addr == 8'hd6 && !cfg_page |->
		##2 $stable(p2_xbar_skip)) else $error("off-page write taken");
	page_read_a: assert property (sfr_rd && sfr_addr == 8'hf3 && !cfg_page |=>
		sfr_rdata == 8'h00) else $error("off-page read answered");
	analog_off_a: assert property ((~p2_rx_en & (p2_pullup_en | p2_pin_oe)) == 8'h00)
		else $error("analog pin still driven or pulled");
	od_pull_a: assert property ((p2_pin_oe & p2_pullup_en) == 8'h00)
		else $error("pullup while driving");
	cover property (sfr_rvalid && sfr_rdata != 8'h00);
	cover property (p2_rx_en != 8'hff);
	cover property (sfr_wr && !cfg_page);
endmodule : pcfg_port_sva
bind pcfg_port pcfg_port_sva i_pcfg_port_sva (
	.sys_clk     (sys_clk),
	.rstn        (rstn),
	.sfr_addr    (sfr_addr),
	.sfr_page    (sfr_page),
	.sfr_wr      (sfr_wr),
	.sfr_wdata   (sfr_wdata),
	.sfr_rd      (sfr_rd),
	.sfr_rdata   (sfr_rdata),
	.sfr_rvalid  (sfr_rvalid),
	.p2_pin_out  (p2_pin_out),
	.p2_pin_oe   (p2_pin_oe),
	.p2_pullup_en(p2_pullup_en),
	.p2_rx_en    (p2_rx_en),
	.p2_xbar_skip(p2_xbar_skip)
);

//--- pcfg_port_test.sv
// Self-checking bench for the port configuration block
`timescale 1ns/1ps
module pcfg_port_test import pcfg_pkg::*;;
	logic       sys_clk = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_bit_wr = 1'b0;
	logic       sfr_bit_val = 1'b0, sfr_rd = 1'b0, sfr_rvalid;
	pcfg_bit_t  sfr_bit_sel = 3'h0;
	pcfg_byte_t sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, ext_en = 8'h00;
	pcfg_byte_t ext_val = 8'h00, sfr_rdata, p2_pin_in, p2_pin_out, p2_pin_oe, p2_pullup_en;
	pcfg_byte_t p2_rx_en, p2_strong_drive, p2_xbar_skip, p3_pin_out, p3_pin_in;
	int         mismatches = 0, num_checks = 0;
	pcfg_port i_pcfg_port (
		.sys_clk        (sys_clk),
		.rstn           (rstn),
		.sfr_addr       (sfr_addr),
		.sfr_page       (sfr_page),
		.sfr_wr         (sfr_wr),
		.sfr_wdata      (sfr_wdata),
		.sfr_bit_wr     (sfr_bit_wr),
		.sfr_bit_sel    (sfr_bit_sel),
		.sfr_bit_val    (sfr_bit_val),
		.sfr_rd         (sfr_rd),
		.sfr_rdata      (sfr_rdata),
		.sfr_rvalid     (sfr_rvalid),
		.p2_pin_in      (p2_pin_in),
		.p2_pin_out     (p2_pin_out),
		.p2_pin_oe      (p2_pin_oe),
		.p2_pullup_en   (p2_pullup_en),
		.p2_rx_en       (p2_rx_en),
		.p2_strong_drive(p2_strong_drive),
		.p2_xbar_skip   (p2_xbar_skip),
		.p3_pin_in      (p3_pin_in),
		.p3_pin_out     (p3_pin_out)
	);
	pcfg_pads i_pcfg_pads (
		.sys_clk     (sys_clk),
		.p2_pin_out  (p2_pin_out),
		.p2_pin_oe   (p2_pin_oe),
		.p2_pullup_en(p2_pullup_en),
		.ext_en      (ext_en),
		.ext_val     (ext_val),
		.p2_pin_in   (p2_pin_in)
	);
	// Port 3 pins follow the latch except where the outside pulls them low
	assign p3_pin_in = p3_pin_out & ~ext_en;
	initial forever #12.5 sys_clk = ~sys_clk;
	////////////////////////////////
	task automatic check(string what, pcfg_byte_t seen, pcfg_byte_t exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	// Byte or bit write; waits until the pins have taken it
	task automatic wr(pcfg_byte_t a, pcfg_byte_t pg, pcfg_byte_t d, logic bw = 1'b0);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_page <= pg;
		sfr_wdata <= d;
		{sfr_bit_val, sfr_bit_sel} <= d[3:0];
		sfr_wr <= ~bw;
		sfr_bit_wr <= bw;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
		sfr_bit_wr <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : wr
	task automatic rd(string what, pcfg_byte_t a, pcfg_byte_t pg, pcfg_byte_t exp);
		@(posedge sys_clk);
		sfr_addr <= a;
		sfr_page <= pg;
		sfr_rd <= 1'b1;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
		#1;
		check(what, sfr_rdata, exp);
		check("read valid", {7'h00, sfr_rvalid}, 8'h01);
	endtask : rd
	task automatic tally_and_finish();
		if (mismatches == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	// The tests need under a hundred cycles; the limit allows 1000
	initial begin
		#25000;
		mismatches++;
		tally_and_finish();
	end
	////////////////////////////////
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd("analog", 8'hf3, 8'h0f, 8'hff);
		rd("otype", 8'ha6, 8'h0f, 8'h00);
		rd("bypass", 8'hd6, 8'h0f, 8'h00);
		rd("drive", 8'hfb, 8'h0f, 8'h00);
		rd("unmapped", 8'h55, 8'h0f, 8'h00);
		rd("offpage", 8'hf3, 8'h00, 8'h00);
		// Open-drain: zeros drive low, ones float up to the pullup
		wr(8'ha0, 8'h00, 8'h55);
		check("p2 latch", p2_pin_out, 8'h55);
		check("p2 oe", p2_pin_oe, 8'haa);
		rd("p2 pins", 8'ha0, 8'h3c, 8'h55);
		wr(8'ha0, 8'h00, 8'hff);
		@(posedge sys_clk);
		ext_en <= 8'h81;
		rd("p2 pins", 8'ha0, 8'h00, 8'h7e);
		// Upper nibble analog, then push-pull everywhere
		wr(8'hf3, 8'h0f, 8'h0f);
		check("pullup", p2_pullup_en, 8'h0f);
		wr(8'ha6, 8'h0f, 8'hff);
		check("rx en", p2_rx_en, 8'h0f);
		check("pullup", p2_pullup_en, 8'h00);
		check("p2 oe", p2_pin_oe, 8'h0f);
		rd("p2 pins", 8'ha0, 8'h00, 8'h0f);
		@(posedge sys_clk);
		ext_en <= 8'h00;
		wr(8'hf3, 8'h0f, 8'hff);
		check("p2 oe", p2_pin_oe, 8'hff);
		wr(8'hd6, 8'h0f, 8'ha5);
		wr(8'hd6, 8'h00, 8'hff);
		check("bypass", p2_xbar_skip, 8'ha5);
		wr(8'hfb, 8'h0f, 8'h3c);
		check("strong", p2_strong_drive, 8'h3c);
		// Single-bit clears: bit 6 of port 2, bit 2 of port 3
		wr(8'ha0, 8'h00, 8'h06, 1'b1);
		check("p2 latch", p2_pin_out, 8'hbf);
		wr(8'hb0, 8'h5a, 8'h02, 1'b1);
		check("p3 latch", p3_pin_out, 8'hfb);
		// Outside pulls port 3 pin 4 low; the read shows the pin, not the latch
		@(posedge sys_clk);
		ext_en <= 8'h10;
		rd("p3 pins", 8'hb0, 8'h5a, 8'heb);
		tally_and_finish();
	end
endmodule : pcfg_port_test
